// ===== status_bank_consts.svh
// Bit positions, masks, reset values and error codes of the status bank
`ifndef STATUS_BANK_CONSTS_SVH
`define STATUS_BANK_CONSTS_SVH

// Standard event register bit positions
`define STD_OPC_BIT      0
`define STD_QERR_BIT     2
`define STD_DDE_BIT      3
`define STD_EXE_BIT      4
`define STD_CME_BIT      5
`define STD_PON_BIT      7
`define STD_USED_MASK    8'hbd
`define STD_FLAGS_RESET  8'h80
`define STD_MASK_RESET   8'h00

// Status byte bit positions
`define STB_ERRQ_BIT     2
`define STB_QUES_BIT     3
`define STB_MAV_BIT      4
`define STB_ESB_BIT      5
`define STB_MSS_BIT      6
`define STB_OPER_BIT     7
`define STB_SRQ_SOURCES  8'hbc
`define STB_RESET        8'h00

// SCPI register layout
`define QUES_POWER_BIT   3
`define QUES_FREQ_BIT    5
`define QUES_LIMIT_BIT   9
`define QUES_USED_MASK   16'h0228
`define FREQ_EXTREF_BIT  8
`define FREQ_USED_MASK   16'h0100
`define OPER_USED_MASK   16'h0000
`define SCPI_RESET       16'h0000

// Error queue codes, two's complement
`define ERR_CODE_DEVICE  16'hfed4
`define ERR_CODE_EXEC    16'hff38
`define ERR_CODE_CMD     16'hff9c
`define ERR_CODE_NONE    16'h0000

`endif

// ===== status_bank_pkg.sv
// Types shared by the status bank modules
package status_bank_pkg;

  typedef logic [7:0]  status_byte_type;
  typedef logic [15:0] status_word_type;

  // Remote-control commands and queries reaching the bank
  typedef enum logic [3:0] {
    CMD_STD_EVENT_Q  = 4'h0,
    CMD_STD_MASK_SET = 4'h1,
    CMD_STD_MASK_Q   = 4'h2,
    CMD_SRQ_MASK_SET = 4'h3,
    CMD_SRQ_MASK_Q   = 4'h4,
    CMD_STB_Q        = 4'h5,
    CMD_OPER_COND_Q  = 4'h6,
    CMD_OPER_EVENT_Q = 4'h7,
    CMD_OPER_ENA_SET = 4'h8,
    CMD_QUES_COND_Q  = 4'h9,
    CMD_QUES_EVENT_Q = 4'ha,
    CMD_QUES_ENA_SET = 4'hb,
    CMD_FREQ_COND_Q  = 4'hc,
    CMD_FREQ_EVENT_Q = 4'hd,
    CMD_FREQ_ENA_SET = 4'he,
    CMD_CLEAR_STATUS = 4'hf
  } command_type;

endpackage

// ===== scpi_status_reg.sv
// One SCPI status register: condition, latched event and enable parts
`timescale 1ns/1ps
`include "status_bank_consts.svh"

module scpi_status_reg
  import status_bank_pkg::*;
#(
  parameter status_word_type USED_MASK = `SCPI_RESET
) (
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            reset_n,
  // Instrument condition
  input  wire status_word_type cond_in,
  // Control from query decoder
  input  wire logic            event_read,
  input  wire logic            clear_all,
  input  wire logic            enable_write,
  input  wire status_word_type enable_data,
  // Register contents
  output status_word_type      cond_q,
  output status_word_type      event_q,
  output status_word_type      enable_q,
  output logic                 summary
);

  status_word_type cond_ff, nxt_cond;
  status_word_type event_ff, nxt_event;
  status_word_type enable_ff, nxt_enable;
  status_word_type rise;

  // Next values; unused bits and bit 15 never set
  always_comb begin
    nxt_cond   = cond_in & USED_MASK;
    rise       = nxt_cond & ~cond_ff;
    nxt_event  = event_ff;
    nxt_enable = enable_ff;
    if (event_read || clear_all) begin
      nxt_event = `SCPI_RESET;
    end
    // [R20] rising edge latch
    // Set wins over a read-clear in the same cycle
    nxt_event = (nxt_event | rise) & USED_MASK;
    if (enable_write) begin
      nxt_enable = enable_data & USED_MASK;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cond_ff   <= `SCPI_RESET;
      event_ff  <= `SCPI_RESET;
      enable_ff <= `SCPI_RESET;
    end else begin
      cond_ff   <= nxt_cond;
      event_ff  <= nxt_event;
      enable_ff <= nxt_enable;
    end
  end

  assign cond_q   = cond_ff;
  assign event_q  = event_ff;
  assign enable_q = enable_ff;
  assign summary  = |(event_ff & enable_ff);

endmodule

// ===== std_event_reg.sv
// Standard event register with its enable mask
`timescale 1ns/1ps
`include "status_bank_consts.svh"

module std_event_reg
  import status_bank_pkg::*;
(
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            reset_n,
  // Event sources and control
  input  wire status_byte_type set_bits,
  input  wire logic            flags_clear,
  input  wire logic            mask_write,
  input  wire status_byte_type mask_data,
  // Register contents
  output status_byte_type      flags_q,
  output status_byte_type      mask_q,
  output logic                 summary
);

  status_byte_type flags_ff, nxt_flags;
  status_byte_type mask_ff, nxt_mask;

  // Next values of flags and mask
  always_comb begin
    nxt_flags = flags_ff;
    nxt_mask  = mask_ff;
    if (flags_clear) begin
      nxt_flags = `STD_MASK_RESET;
    end
    // [R01] latched until read
    // New events beat a clear in the same cycle
    nxt_flags = (nxt_flags | set_bits) & `STD_USED_MASK;
    // [R02] mask write
    if (mask_write) begin
      nxt_mask = mask_data & `STD_USED_MASK;
    end
  end

  // [R08] power on flag
  // Reset loads the power-on bit so it reads set after switch-on
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flags_ff <= `STD_FLAGS_RESET;
      mask_ff  <= `STD_MASK_RESET;
    end else begin
      flags_ff <= nxt_flags;
      mask_ff  <= nxt_mask;
    end
  end

  assign flags_q = flags_ff;
  assign mask_q  = mask_ff;
  // [R16] event summary
  assign summary = |(flags_ff & mask_ff);

endmodule

// ===== event_and_scpi_status_bank.sv
// Status reporting bank: standard events, SCPI registers, status byte
// What this block does
// [R01] Standard event flags stay set until read by their query or cleared.
// [R02] Eight-bit standard event mask, written and read back by commands.
// [R03] Bit 0 sets once operation-complete seen and earlier commands finished.
// [R04] Bit 2 sets on read without query or unfetched response.
// [R05] Bit 3 sets on device error; queue code -300.
// [R06] Bit 4 sets on execution error; queue code -200.
// [R07] Bit 5 sets on command error; queue code -100.
// [R08] Bit 7 sets when the instrument is switched on.
// [R09] Operation condition shows current actions; event shows actions since read.
// [R10] Bit 15 of SCPI registers reads zero; operation bits unused.
// [R11] Questionable bit 3 follows questionable power on any channel.
// [R12] Questionable bit 5 follows oscillator or reference frequency fault.
// [R13] Questionable bit 9 follows limit violation.
// [R14] Frequency bit 8 follows external reference use; others unused.
// [R15] Questionable condition and event answered by separate queries.
// [R16] Status byte bit 5 set when enabled standard event set.
// [R17] Status byte bit 3 set when enabled questionable event set.
// [R18] Service request when enabled status byte bit 2,3,4,5 or 7 set.
// [R19] Unused status bits read zero and cannot be set.
// [R20] SCPI event bits latch on condition rise, clear on event query.
`timescale 1ns/1ps
`include "status_bank_consts.svh"

module event_and_scpi_status_bank
  import status_bank_pkg::*;
(
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            reset_n,
  // Command and query port
  input  wire logic            cmd_valid,
  input  wire command_type     cmd_code,
  input  wire status_word_type cmd_data,
  output logic                 resp_valid,
  output status_word_type      resp_data,
  // Command execution events
  input  wire logic            opc_received,
  input  wire logic            cmds_pending,
  input  wire logic            read_without_query,
  input  wire logic            response_abandoned,
  input  wire logic            device_error,
  input  wire logic            execution_error,
  input  wire logic            command_error,
  // Error queue entry
  output logic                 err_push,
  output status_word_type      err_code,
  // Instrument conditions
  input  wire status_word_type oper_actions,
  input  wire logic            power_questionable,
  input  wire logic            freq_fault,
  input  wire logic            limit_violated,
  input  wire logic            ext_ref_in_use,
  // Status byte sources
  input  wire logic            err_queue_not_empty,
  input  wire logic            msg_available,
  // Status byte and service request
  output status_byte_type      status_byte,
  output logic                 service_request
);

  // Decoded command strobes
  logic            std_event_rd;
  logic            std_mask_wr;
  logic            srq_mask_wr;
  logic            oper_event_rd;
  logic            oper_ena_wr;
  logic            ques_event_rd;
  logic            ques_ena_wr;
  logic            freq_event_rd;
  logic            freq_ena_wr;
  logic            clear_status;

  // Register contents from submodules
  status_byte_type std_flags;
  status_byte_type std_mask;
  logic            std_summary;
  status_word_type oper_cond;
  status_word_type oper_event;
  status_word_type oper_ena;
  logic            oper_summary;
  status_word_type ques_cond;
  status_word_type ques_event;
  status_word_type ques_ena;
  logic            ques_summary;
  status_word_type freq_cond;
  status_word_type freq_event;
  status_word_type freq_ena;
  logic            freq_summary;

  // Local state
  logic            opc_armed_ff, nxt_opc_armed;
  logic            opc_done;
  status_byte_type std_set;
  status_byte_type srq_mask_ff, nxt_srq_mask;
  status_byte_type stb_ff, nxt_stb;
  logic            srq_ff, nxt_srq;
  logic            resp_valid_ff, nxt_resp_valid;
  status_word_type resp_data_ff, nxt_resp_data;
  logic            err_push_ff, nxt_err_push;
  status_word_type err_code_ff, nxt_err_code;
  status_word_type ques_cond_in;
  status_word_type freq_cond_in;

  // True when a command code selects the given command
  function automatic logic is_cmd(input logic vld, input command_type code,
                                  input command_type want);
    is_cmd = vld && (code == want);
  endfunction

  // Command decode
  assign std_event_rd  = is_cmd(cmd_valid, cmd_code, CMD_STD_EVENT_Q);
  assign std_mask_wr   = is_cmd(cmd_valid, cmd_code, CMD_STD_MASK_SET);
  assign srq_mask_wr   = is_cmd(cmd_valid, cmd_code, CMD_SRQ_MASK_SET);
  assign oper_event_rd = is_cmd(cmd_valid, cmd_code, CMD_OPER_EVENT_Q);
  assign oper_ena_wr   = is_cmd(cmd_valid, cmd_code, CMD_OPER_ENA_SET);
  assign ques_event_rd = is_cmd(cmd_valid, cmd_code, CMD_QUES_EVENT_Q);
  assign ques_ena_wr   = is_cmd(cmd_valid, cmd_code, CMD_QUES_ENA_SET);
  assign freq_event_rd = is_cmd(cmd_valid, cmd_code, CMD_FREQ_EVENT_Q);
  assign freq_ena_wr   = is_cmd(cmd_valid, cmd_code, CMD_FREQ_ENA_SET);
  assign clear_status  = is_cmd(cmd_valid, cmd_code, CMD_CLEAR_STATUS);

  // Operation-complete arming; a completion in the arming cycle counts
  always_comb begin
    nxt_opc_armed = opc_armed_ff;
    opc_done      = 1'b0;
    // [R03] wait for earlier commands
    if ((opc_armed_ff || opc_received) && !cmds_pending) begin
      opc_done      = 1'b1;
      nxt_opc_armed = 1'b0;
    end else if (opc_received) begin
      nxt_opc_armed = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      opc_armed_ff <= 1'b0;
    end else begin
      opc_armed_ff <= nxt_opc_armed;
    end
  end

  // Standard event sources
  always_comb begin
    std_set = `STD_MASK_RESET;
    std_set[`STD_OPC_BIT] = opc_done;
    // [R04] query error sources
    std_set[`STD_QERR_BIT] = read_without_query || response_abandoned;
    // [R05] device error flag
    std_set[`STD_DDE_BIT] = device_error;
    // [R06] execution error flag
    std_set[`STD_EXE_BIT] = execution_error;
    // [R07] command error flag
    std_set[`STD_CME_BIT] = command_error;
  end

  // Error queue entry; command errors win when several arrive at once
  always_comb begin
    nxt_err_push = device_error || execution_error || command_error;
    nxt_err_code = `ERR_CODE_NONE;
    // [R07] command error code
    if (command_error) begin
      nxt_err_code = `ERR_CODE_CMD;
    // [R06] execution error code
    end else if (execution_error) begin
      nxt_err_code = `ERR_CODE_EXEC;
    // [R05] device error code
    end else if (device_error) begin
      nxt_err_code = `ERR_CODE_DEVICE;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      err_push_ff <= 1'b0;
      err_code_ff <= `ERR_CODE_NONE;
    end else begin
      err_push_ff <= nxt_err_push;
      err_code_ff <= nxt_err_code;
    end
  end

  std_event_reg u_std_event (
    .mclk        (mclk),
    .reset_n     (reset_n),
    .set_bits    (std_set),
    .flags_clear (std_event_rd || clear_status),
    .mask_write  (std_mask_wr),
    .mask_data   (cmd_data[7:0]),
    .flags_q     (std_flags),
    .mask_q      (std_mask),
    .summary     (std_summary)
  );

  // Questionable and frequency condition inputs
  always_comb begin
    ques_cond_in = `SCPI_RESET;
    // [R11] power questionable
    ques_cond_in[`QUES_POWER_BIT] = power_questionable;
    // [R12] frequency fault
    ques_cond_in[`QUES_FREQ_BIT] = freq_fault;
    // [R13] limit violation
    ques_cond_in[`QUES_LIMIT_BIT] = limit_violated;
    freq_cond_in = `SCPI_RESET;
    // [R14] external reference
    freq_cond_in[`FREQ_EXTREF_BIT] = ext_ref_in_use;
  end

  // [R09] operation condition and event
  // [R10] operation bits masked off
  scpi_status_reg #(
    .USED_MASK (`OPER_USED_MASK)
  ) u_oper (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .cond_in      (oper_actions),
    .event_read   (oper_event_rd),
    .clear_all    (clear_status),
    .enable_write (oper_ena_wr),
    .enable_data  (cmd_data),
    .cond_q       (oper_cond),
    .event_q      (oper_event),
    .enable_q     (oper_ena),
    .summary      (oper_summary)
  );

  scpi_status_reg #(
    .USED_MASK (`QUES_USED_MASK)
  ) u_ques (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .cond_in      (ques_cond_in),
    .event_read   (ques_event_rd),
    .clear_all    (clear_status),
    .enable_write (ques_ena_wr),
    .enable_data  (cmd_data),
    .cond_q       (ques_cond),
    .event_q      (ques_event),
    .enable_q     (ques_ena),
    .summary      (ques_summary)
  );

  // Frequency summary has no status byte position here
  scpi_status_reg #(
    .USED_MASK (`FREQ_USED_MASK)
  ) u_freq (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .cond_in      (freq_cond_in),
    .event_read   (freq_event_rd),
    .clear_all    (clear_status),
    .enable_write (freq_ena_wr),
    .enable_data  (cmd_data),
    .cond_q       (freq_cond),
    .event_q      (freq_event),
    .enable_q     (freq_ena),
    .summary      (freq_summary)
  );

  // Status byte and service request
  always_comb begin
    nxt_srq_mask = srq_mask_ff;
    if (srq_mask_wr) begin
      // [R19] only summary positions kept
      nxt_srq_mask = cmd_data[7:0] & `STB_SRQ_SOURCES;
    end
    nxt_stb = `STB_RESET;
    nxt_stb[`STB_ERRQ_BIT] = err_queue_not_empty;
    // [R17] questionable summary
    nxt_stb[`STB_QUES_BIT] = ques_summary;
    nxt_stb[`STB_MAV_BIT]  = msg_available;
    // [R16] event summary bit
    nxt_stb[`STB_ESB_BIT]  = std_summary;
    nxt_stb[`STB_OPER_BIT] = oper_summary;
    // [R18] service request
    nxt_srq = |(nxt_stb & srq_mask_ff & `STB_SRQ_SOURCES);
    nxt_stb[`STB_MSS_BIT] = nxt_srq;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      srq_mask_ff <= `STB_RESET;
      stb_ff      <= `STB_RESET;
      srq_ff      <= 1'b0;
    end else begin
      srq_mask_ff <= nxt_srq_mask;
      stb_ff      <= nxt_stb;
      srq_ff      <= nxt_srq;
    end
  end

  // Query answers; register values are sampled before any read-clear
  always_comb begin
    nxt_resp_valid = 1'b0;
    nxt_resp_data  = `SCPI_RESET;
    if (cmd_valid) begin
      nxt_resp_valid = 1'b1;
      unique case (cmd_code)
        CMD_STD_EVENT_Q:  nxt_resp_data = {8'h00, std_flags};
        CMD_STD_MASK_Q:   nxt_resp_data = {8'h00, std_mask};
        CMD_SRQ_MASK_Q:   nxt_resp_data = {8'h00, srq_mask_ff};
        CMD_STB_Q:        nxt_resp_data = {8'h00, stb_ff};
        CMD_OPER_COND_Q:  nxt_resp_data = oper_cond;
        CMD_OPER_EVENT_Q: nxt_resp_data = oper_event;
        // [R15] separate questionable parts
        CMD_QUES_COND_Q:  nxt_resp_data = ques_cond;
        CMD_QUES_EVENT_Q: nxt_resp_data = ques_event;
        CMD_FREQ_COND_Q:  nxt_resp_data = freq_cond;
        CMD_FREQ_EVENT_Q: nxt_resp_data = freq_event;
        CMD_STD_MASK_SET, CMD_SRQ_MASK_SET, CMD_OPER_ENA_SET,
        CMD_QUES_ENA_SET, CMD_FREQ_ENA_SET, CMD_CLEAR_STATUS: begin
          nxt_resp_valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      resp_valid_ff <= 1'b0;
      resp_data_ff  <= `SCPI_RESET;
    end else begin
      resp_valid_ff <= nxt_resp_valid;
      resp_data_ff  <= nxt_resp_data;
    end
  end

  // Outputs; enable parts are write-only at this port
  assign resp_valid      = resp_valid_ff;
  assign resp_data       = resp_data_ff;
  assign err_push        = err_push_ff;
  assign err_code        = err_code_ff;
  assign status_byte     = stb_ff;
  assign service_request = srq_ff;

endmodule

// ===== status_bank_asserts.sv
// Port-level checks of the status bank
`timescale 1ns/1ps
module status_bank_checker
  import status_bank_pkg::*;
(
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            reset_n,
  // Command port
  input  wire logic            cmd_valid,
  input  wire command_type     cmd_code,
  input  wire logic            resp_valid,
  input  wire status_word_type resp_data,
  // Errors
  input  wire logic            device_error,
  input  wire logic            execution_error,
  input  wire logic            command_error,
  input  wire logic            err_push,
  input  wire status_word_type err_code,
  // Conditions and status byte
  input  wire logic            power_questionable,
  input  wire logic            freq_fault,
  input  wire logic            limit_violated,
  input  wire logic            ext_ref_in_use,
  input  wire logic            err_queue_not_empty,
  input  wire status_byte_type status_byte,
  input  wire logic            service_request
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic is_query;
  // Queries are the codes that expect an answer
  assign is_query = cmd_valid && (cmd_code inside {CMD_STD_EVENT_Q, CMD_STD_MASK_Q,
    CMD_SRQ_MASK_Q, CMD_STB_Q, CMD_OPER_COND_Q, CMD_OPER_EVENT_Q, CMD_QUES_COND_Q,
    CMD_QUES_EVENT_Q, CMD_FREQ_COND_Q, CMD_FREQ_EVENT_Q});
  property p_query_answer; is_query |=> resp_valid; endproperty
  a_query_answer: assert property (p_query_answer) else $error("query unanswered");
  property p_no_answer; !is_query |=> !resp_valid; endproperty
  a_no_answer: assert property (p_no_answer) else $error("spurious answer");
  // Condition reaches answer two edges after the input
  property p_ques_cond;
    cmd_valid && cmd_code == CMD_QUES_COND_Q |=> resp_data == {6'h00,
      $past(limit_violated, 2), 3'h0, $past(freq_fault, 2), 1'b0, $past(power_questionable, 2), 3'h0};
  endproperty
  a_ques_cond: assert property (p_ques_cond) else $error("ques cond wrong");
  property p_freq_cond;
    cmd_valid && cmd_code == CMD_FREQ_COND_Q |=> resp_data == {7'h00, $past(ext_ref_in_use, 2), 8'h00};
  endproperty
  a_freq_cond: assert property (p_freq_cond) else $error("freq cond wrong");
  property p_oper_zero;
    cmd_valid && (cmd_code inside {CMD_OPER_COND_Q, CMD_OPER_EVENT_Q}) |=> resp_data == 16'h0000;
  endproperty
  a_oper_zero: assert property (p_oper_zero) else $error("oper not zero");
  property p_err_cmd; command_error |=> err_push && err_code == 16'hff9c; endproperty
  a_err_cmd: assert property (p_err_cmd) else $error("command error code");
  property p_err_exe;
    execution_error && !command_error |=> err_push && err_code == 16'hff38;
  endproperty
  a_err_exe: assert property (p_err_exe) else $error("execution error code");
  property p_err_dev;
    device_error && !execution_error && !command_error |=> err_push && err_code == 16'hfed4;
  endproperty
  a_err_dev: assert property (p_err_dev) else $error("device error code");
  property p_errq_bit; $past(reset_n) |-> status_byte[2] == $past(err_queue_not_empty); endproperty
  a_errq_bit: assert property (p_errq_bit) else $error("status byte bit 2");
  property p_srq_copy; service_request == status_byte[6]; endproperty
  a_srq_copy: assert property (p_srq_copy) else $error("service request mismatch");
  property p_unused_stb; status_byte[1:0] == 2'b00; endproperty
  a_unused_stb: assert property (p_unused_stb) else $error("unused status bits set");
endmodule

bind event_and_scpi_status_bank status_bank_checker u_chk (.mclk, .reset_n, .cmd_valid,
  .cmd_code, .resp_valid, .resp_data, .device_error, .execution_error, .command_error,
  .err_push, .err_code, .power_questionable, .freq_fault, .limit_violated,
  .ext_ref_in_use, .err_queue_not_empty, .status_byte, .service_request);

// ===== status_controller.sv
// Remote controller model issuing commands and collecting answers
`timescale 1ns/1ps
module status_controller
  import status_bank_pkg::*;
(
  // Clock
  input  wire logic            mclk,
  // Command port
  output logic                 cmd_valid,
  output command_type          cmd_code,
  output status_word_type      cmd_data,
  input  wire logic            resp_valid,
  input  wire status_word_type resp_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = CMD_STD_EVENT_Q;
    cmd_data  = 16'h0000;
  end
  task automatic send(input command_type code, input status_word_type data,
                      output logic got_valid, output status_word_type got_data);
    // Random idle time, so both prompt and slow controllers are seen
    repeat (1 + $urandom_range(0, 2)) @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    cmd_data  <= data;
    @(posedge mclk);
    // Released lines change, so stale data is never taken as valid
    cmd_valid <= 1'b0;
    cmd_code  <= command_type'(~code);
    cmd_data  <= ~data;
    @(posedge mclk);
    got_valid = resp_valid;
    got_data  = resp_data;
  endtask
endmodule

// ===== tb.sv
// Self-checking bench for the status bank
`timescale 1ns/1ps
module tb
  import status_bank_pkg::*;
();
  logic            mclk, reset_n, cmd_valid, resp_valid, err_push, service_request;
  logic            cmds_pending, err_q, mav, ext_ref, gv, xr, px;
  logic [5:0]      ev;
  logic [2:0]      qc, nq, pq;
  command_type     cmd_code;
  status_word_type cmd_data, resp_data, err_code, oper_actions, gd, d;
  status_byte_type status_byte;
  int              err_total, n_checks;
  int              std_bit [6] = '{0, 2, 2, 3, 4, 5};

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  status_controller ctrl (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .resp_valid(resp_valid), .resp_data(resp_data));
  event_and_scpi_status_bank DUT (.mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .resp_valid(resp_valid), .resp_data(resp_data),
    .opc_received(ev[0]), .cmds_pending(cmds_pending), .read_without_query(ev[1]),
    .response_abandoned(ev[2]), .device_error(ev[3]), .execution_error(ev[4]),
    .command_error(ev[5]), .err_push(err_push), .err_code(err_code),
    .oper_actions(oper_actions), .power_questionable(qc[0]), .freq_fault(qc[1]),
    .limit_violated(qc[2]), .ext_ref_in_use(ext_ref), .err_queue_not_empty(err_q),
    .msg_available(mav), .status_byte(status_byte), .service_request(service_request));

  // Expected questionable word from power, frequency and limit
  function automatic status_word_type ques_word(input logic [2:0] c);
    return {6'h00, c[2], 3'h0, c[1], 1'b0, c[0], 3'h0};
  endfunction

  task automatic check(input string what, input status_word_type exp, input status_word_type got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic query(input command_type c, input string what, input status_word_type exp);
    ctrl.send(c, 16'h0000, gv, gd);
    check({what, " valid"}, 16'h0001, {15'h0000, gv});
    check(what, exp, gd);
  endtask
  task automatic put(input command_type c, input status_word_type v);
    ctrl.send(c, v, gv, gd);
  endtask
  task automatic pulse(input int i);
    @(posedge mclk);
    ev[i] <= 1'b1;
    @(posedge mclk);
    ev[i] <= 1'b0;
  endtask
  // Summary bits seen after sources settle: {srq, b5..b2}
  task automatic sum_check(input status_word_type exp);
    repeat (4) @(posedge mclk);
    check("summary", exp, {11'h000, service_request, status_byte[5:2]});
  endtask
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    report_and_stop();
  end

  initial begin
    {ev, cmds_pending, err_q, mav, qc, ext_ref, reset_n} = '0;
    oper_actions = 16'h0000;
    err_total = 0;
    n_checks = 0;
    void'($urandom(32'h79f1));
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    query(CMD_STD_EVENT_Q, "power on flag", 16'h0080);
    query(CMD_STD_EVENT_Q, "flags after read", 16'h0000);
    query(CMD_STD_MASK_Q, "mask reset", 16'h0000);
    $display("Test reset values done");
    // Mask with edge values then random ones
    for (int k = 0; k < 6; k++) begin
      d = (k == 0) ? 16'h0042 : (k == 1) ? 16'hffff : 16'($urandom);
      put(CMD_STD_MASK_SET, d);
      query(CMD_STD_MASK_Q, "std mask", {8'h00, d[7:0] & 8'hbd});
    end
    $display("Test mask done");
    for (int i = 0; i < 6; i++) begin
      pulse(i);
      query(CMD_STD_EVENT_Q, "event bit", 16'h0001 << std_bit[i]);
      query(CMD_STD_EVENT_Q, "event cleared", 16'h0000);
    end
    pulse(3);
    pulse(5);
    query(CMD_STD_EVENT_Q, "events held", 16'h0028);
    cmds_pending <= 1'b1;
    pulse(0);
    query(CMD_STD_EVENT_Q, "opc pending", 16'h0000);
    cmds_pending <= 1'b0;
    query(CMD_STD_EVENT_Q, "opc finished", 16'h0001);
    $display("Test standard events done");
    for (int k = 0; k < 8; k++) begin
      pq = qc;
      px = ext_ref;
      nq = (k == 0) ? 3'b111 : 3'($urandom);
      xr = 1'($urandom);
      @(posedge mclk);
      qc <= nq;
      ext_ref <= xr;
      oper_actions <= 16'($urandom);
      repeat (3) @(posedge mclk);
      query(CMD_QUES_COND_Q, "ques cond", ques_word(nq));
      query(CMD_QUES_EVENT_Q, "ques event", ques_word(nq & ~pq));
      query(CMD_QUES_EVENT_Q, "ques event reread", 16'h0000);
      query(CMD_FREQ_COND_Q, "freq cond", {7'h00, xr, 8'h00});
      query(CMD_FREQ_EVENT_Q, "freq event", {7'h00, xr & ~px, 8'h00});
      query(CMD_OPER_COND_Q, "oper cond", 16'h0000);
      query(CMD_OPER_EVENT_Q, "oper event", 16'h0000);
    end
    $display("Test SCPI registers done");
    qc <= 3'b000;
    put(CMD_STD_MASK_SET, 16'h0020);
    put(CMD_SRQ_MASK_SET, 16'h00ff);
    query(CMD_SRQ_MASK_Q, "srq mask", 16'h00bc);
    put(CMD_QUES_ENA_SET, 16'hffff);
    put(CMD_OPER_ENA_SET, 16'hffff);
    put(CMD_FREQ_ENA_SET, 16'hffff);
    pulse(5);
    qc <= 3'b001;
    sum_check(16'h001a);
    put(CMD_CLEAR_STATUS, 16'h0000);
    sum_check(16'h0000);
    err_q <= 1'b1;
    sum_check(16'h0011);
    put(CMD_SRQ_MASK_SET, 16'h0010);
    sum_check(16'h0001);
    mav <= 1'b1;
    sum_check(16'h0015);
    // Operation summary must stay clear although its enable was written
    query(CMD_STB_Q, "status byte", 16'h0054);
    $display("Test summaries done");
    report_and_stop();
  end
endmodule
